// ==== hdl/ddr_guard_pkg.sv ====
// Timing constants, command codes and helper functions for the DDR command guard
package ddr_guard_pkg;
  // ==================================================
  // Clocking and widths
  localparam int CLK_PERIOD_NS = 100;
  localparam int CK_DIV        = 2;
  localparam int BURST_LEN     = 4;
  localparam int NUM_BANKS     = 4;
  localparam int CNT_W         = 12;
  localparam int BAL_W         = 5;
  localparam int STEP_W        = 3;

  // ==================================================
  // Minimum and maximum times, as printed
  localparam int ACT_TO_RW_MIN_NS_FAST               = 18;
  localparam int ACT_TO_RW_MIN_NS_SLOW               = 20;
  localparam int ACT_TO_ACT_SAME_BANK_MIN_NS_FAST    = 60;
  localparam int ACT_TO_ACT_SAME_BANK_MIN_NS_SLOW    = 65;
  localparam int REFRESH_CYCLE_MIN_NS_FAST           = 72;
  localparam int REFRESH_CYCLE_MIN_NS_SLOW           = 75;
  localparam int ACT_TO_ACT_OTHER_BANK_MIN_NS_FAST   = 12;
  localparam int ACT_TO_ACT_OTHER_BANK_MIN_NS_SLOW   = 15;
  localparam int ACT_TO_PRE_MIN_NS_FAST              = 42;
  localparam int ACT_TO_PRE_MIN_NS_SLOW              = 40;
  localparam int SELFREF_EXIT_NONREAD_WAIT_NS        = 75;
  localparam int SELFREF_EXIT_READ_WAIT_CK           = 200;
  localparam int DLL_RESET_WAIT_CK                   = 200;
  localparam int WRITE_TO_READ_GAP_CK                = 1;
  localparam int REFRESH_GAP_MAX_NS_SMALL            = 140600;
  localparam int REFRESH_GAP_MAX_NS_LARGE            = 70300;
  localparam int REFRESH_INTERVAL_AVG_NS_SMALL       = 15600;
  localparam int REFRESH_INTERVAL_AVG_NS_LARGE       = 7800;
  localparam int REFRESH_POSTPONE_MAX                = 8;
  localparam int REFRESH_FORCE_MARGIN_CYC            = 40;

  // ==================================================
  // Command codes on cs_n, ras_n, cas_n, we_n
  localparam logic [3:0] PIN_MRS   = 4'h0;
  localparam logic [3:0] PIN_REF   = 4'h1;
  localparam logic [3:0] PIN_PRE   = 4'h2;
  localparam logic [3:0] PIN_ACT   = 4'h3;
  localparam logic [3:0] PIN_WRITE = 4'h4;
  localparam logic [3:0] PIN_READ  = 4'h5;
  localparam logic [3:0] PIN_NOP   = 4'h7;

  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_ACT        = 4'h1,
    CMD_READ       = 4'h2,
    CMD_WRITE      = 4'h3,
    CMD_READ_AP    = 4'h4,
    CMD_WRITE_AP   = 4'h5,
    CMD_PRE        = 4'h6,
    CMD_REF        = 4'h7,
    CMD_SREF_ENTER = 4'h8,
    CMD_SREF_EXIT  = 4'h9,
    CMD_DLL_RESET  = 4'hA
  } cmd_type;

  typedef enum logic [0:0] {
    ST_RUN     = 1'b0,
    ST_SELFREF = 1'b1
  } state_type;

  // Least time: round up, never below one cycle
  function automatic int min_cyc(int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time: round down, never below one cycle
  function automatic int max_cyc(int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
endpackage

// ==== hdl/ddr_guard_host.sv ====
// Host command issuer that spaces DDR commands and keeps refresh obligations
// What this block does
// - Read-with-autoprecharge waits act-to-rw after activate
// - Same-bank activate/refresh waits act-to-act time
// - Refresh cycle time before next activate/refresh
// - Read or write waits act-to-rw after activate
// - Activates to different banks spaced minimum apart
// - One clock after last write data before read
// - Refresh gap kept within maximum except while a DLL reset wait blocks the forced refresh
// - Refresh issued at required average interval
// - Self-refresh exit waits before non-read commands
// - Self-refresh exit waits 200 clocks before read
// - Write strobe preamble starts at write command
// - Negative preamble setup allowed, costs turnaround
// - Strobe driven low at or before write
// - Longer write postamble accepted, slower turnaround
// - At most eight refreshes bursted; more than eight postponed while a DLL reset wait blocks refresh
// - Clock enable high throughout refresh cycle
// - DLL reset then 200 clocks before operation
// - Autoprecharge only once act-to-pre time met
`timescale 1ns/1ps
module ddr_guard_host
  import ddr_guard_pkg::*;
#(
  parameter bit FAST_GRADE   = 1'b1,
  parameter bit LARGE_MODULE = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req_valid,
  input  wire cmd_type    req_cmd,
  input  wire logic [1:0] req_bank,
  output logic            req_ack,
  output logic            ck_out,
  output logic            ck_n_out,
  output logic            cke,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic [1:0]      ba,
  output logic            addr_flag,
  output logic            dqs_o,
  output logic            dqs_oe,
  input  wire logic       dqs_i,
  output logic            read_strobe_seen
);
  // ==================================================
  // Cycle counts
  localparam int RW_CYC   = min_cyc(FAST_GRADE ? ACT_TO_RW_MIN_NS_FAST
                                               : ACT_TO_RW_MIN_NS_SLOW);
  localparam int RC_CYC   = min_cyc(FAST_GRADE ? ACT_TO_ACT_SAME_BANK_MIN_NS_FAST
                                               : ACT_TO_ACT_SAME_BANK_MIN_NS_SLOW);
  localparam int RFC_CYC  = min_cyc(FAST_GRADE ? REFRESH_CYCLE_MIN_NS_FAST
                                               : REFRESH_CYCLE_MIN_NS_SLOW);
  localparam int RRD_CYC  = min_cyc(FAST_GRADE ? ACT_TO_ACT_OTHER_BANK_MIN_NS_FAST
                                               : ACT_TO_ACT_OTHER_BANK_MIN_NS_SLOW);
  localparam int RAS_CYC  = min_cyc(FAST_GRADE ? ACT_TO_PRE_MIN_NS_FAST : ACT_TO_PRE_MIN_NS_SLOW);
  localparam int XSNR_CYC = min_cyc(SELFREF_EXIT_NONREAD_WAIT_NS);
  localparam int XSRD_CYC = SELFREF_EXIT_READ_WAIT_CK * CK_DIV;
  localparam int DLL_CYC  = DLL_RESET_WAIT_CK * CK_DIV;
  localparam int WTR_CYC  = CK_DIV * (1 + BURST_LEN / 2) + 1 + CK_DIV * WRITE_TO_READ_GAP_CK;
  localparam int REFC_CYC = max_cyc(LARGE_MODULE ? REFRESH_GAP_MAX_NS_LARGE
                                                 : REFRESH_GAP_MAX_NS_SMALL);
  localparam int REFI_CYC = max_cyc(LARGE_MODULE ? REFRESH_INTERVAL_AVG_NS_LARGE
                                                 : REFRESH_INTERVAL_AVG_NS_SMALL);
  localparam int DQS_LAST = CK_DIV + BURST_LEN;

  function automatic logic [CNT_W-1:0] cnt_dec(logic [CNT_W-1:0] v);
    return (v == '0) ? '0 : v - 1'b1;
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(logic [CNT_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction

  logic [CNT_W-1:0] rw_cnt_r  [NUM_BANKS];
  logic [CNT_W-1:0] rc_cnt_r  [NUM_BANKS];
  logic [CNT_W-1:0] ras_cnt_r [NUM_BANKS];
  logic [CNT_W-1:0] rrd_cnt_r, rfc_cnt_r, wtr_cnt_r, xsnr_cnt_r, xsrd_cnt_r;
  logic [CNT_W-1:0] refi_cnt_r, refc_cnt_r;
  logic [BAL_W-1:0] bal_r;
  logic [STEP_W-1:0] dqs_step_r;
  state_type        state_r;
  logic             ck_r, dqs_s1_r, dqs_s2_r, dqs_s3_r;
  logic             ok, ref_ok, force_ref, take, issue, rc_all_zero, fire_flag;
  logic [3:0]       fire_pin;
  logic [1:0]       fire_bank;
  logic             slot;

  // ==================================================
  // Command choice
  assign slot = ck_r;

  always_comb begin
    rc_all_zero = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (rc_cnt_r[i] != '0) rc_all_zero = 1'b0;
    end
  end

  always_comb begin
    ref_ok    = rc_all_zero && rfc_cnt_r == '0 && xsnr_cnt_r == '0 && bal_r != '0;
    force_ref = state_r == ST_RUN && (bal_r == BAL_W'(2 * REFRESH_POSTPONE_MAX)
                || refc_cnt_r <= CNT_W'(REFRESH_FORCE_MARGIN_CYC));
    ok        = 1'b0;
    fire_pin  = PIN_NOP;
    fire_flag = 1'b0;
    if (state_r == ST_SELFREF) begin
      ok = req_cmd == CMD_SREF_EXIT;
    end else begin
      unique case (req_cmd)
        CMD_ACT: begin
          ok       = rc_cnt_r[req_bank] == '0 && rrd_cnt_r == '0
                     && rfc_cnt_r == '0 && xsnr_cnt_r == '0;
          fire_pin = PIN_ACT;
        end
        CMD_READ, CMD_READ_AP: begin
          ok        = rw_cnt_r[req_bank] == '0 && wtr_cnt_r == '0
                      && xsrd_cnt_r == '0
                      && (req_cmd == CMD_READ || ras_cnt_r[req_bank] == '0);
          fire_pin  = PIN_READ;
          fire_flag = req_cmd == CMD_READ_AP;
        end
        CMD_WRITE, CMD_WRITE_AP: begin
          ok        = rw_cnt_r[req_bank] == '0 && xsnr_cnt_r == '0
                      && (req_cmd == CMD_WRITE || ras_cnt_r[req_bank] == '0);
          fire_pin  = PIN_WRITE;
          fire_flag = req_cmd == CMD_WRITE_AP;
        end
        CMD_PRE: begin
          ok       = ras_cnt_r[req_bank] == '0 && xsnr_cnt_r == '0;
          fire_pin = PIN_PRE;
        end
        CMD_REF, CMD_SREF_ENTER: begin
          ok       = ref_ok;
          fire_pin = PIN_REF;
        end
        CMD_DLL_RESET: begin
          ok        = xsnr_cnt_r == '0 && rfc_cnt_r == '0;
          fire_pin  = PIN_MRS;
          fire_flag = 1'b1;
        end
        default: ok = 1'b1;
      endcase
    end
    take  = slot && req_valid && ok && !force_ref;
    issue = take || (slot && force_ref && ref_ok);
    if (!take) begin
      fire_pin  = (issue) ? PIN_REF : PIN_NOP;
      fire_flag = 1'b0;
    end
  end
  assign fire_bank = req_bank;

  // ==================================================
  // Link clock and command pins
  always_ff @(posedge clk) begin
    if (rst) begin
      ck_r     <= 1'b0;
      ck_n_out <= 1'b1;
    end else begin
      ck_r     <= !ck_r;
      ck_n_out <= ck_r;
    end
  end
  assign ck_out = ck_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      {cs_n, ras_n, cas_n, we_n} <= PIN_NOP;
      ba        <= 2'h0;
      addr_flag <= 1'b0;
      req_ack   <= 1'b0;
    end else begin
      req_ack <= take;
      if (slot) begin
        {cs_n, ras_n, cas_n, we_n} <= fire_pin;
        ba        <= fire_bank;
        addr_flag <= fire_flag;
      end
    end
  end

  // ==================================================
  // Power state and clock enable
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_RUN;
      cke     <= 1'b1;
    end else if (take && req_cmd == CMD_SREF_ENTER) begin
      state_r <= ST_SELFREF;
      cke     <= 1'b0;
    end else if (take && req_cmd == CMD_SREF_EXIT) begin
      state_r <= ST_RUN;
      cke     <= 1'b1;
    end
  end

  // ==================================================
  // Per-bank spacing
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge clk) begin
      if (rst) begin
        rw_cnt_r[b]  <= '0;
        rc_cnt_r[b]  <= '0;
        ras_cnt_r[b] <= '0;
      end else if (take && fire_pin == PIN_ACT && fire_bank == 2'(b)) begin
        rw_cnt_r[b]  <= CNT_W'(RW_CYC - 1);
        rc_cnt_r[b]  <= CNT_W'(RC_CYC - 1);
        ras_cnt_r[b] <= CNT_W'(RAS_CYC - 1);
      end else begin
        rw_cnt_r[b]  <= cnt_dec(rw_cnt_r[b]);
        rc_cnt_r[b]  <= cnt_dec(rc_cnt_r[b]);
        ras_cnt_r[b] <= cnt_dec(ras_cnt_r[b]);
      end
    end
  end

  // ==================================================
  // Shared spacing counters
  always_ff @(posedge clk) begin
    if (rst) begin
      rrd_cnt_r <= '0;
      rfc_cnt_r <= '0;
      wtr_cnt_r <= '0;
    end else begin
      rrd_cnt_r <= (take && fire_pin == PIN_ACT) ? CNT_W'(RRD_CYC - 1) : cnt_dec(rrd_cnt_r);
      rfc_cnt_r <= (issue && fire_pin == PIN_REF) ? CNT_W'(RFC_CYC - 1) : cnt_dec(rfc_cnt_r);
      wtr_cnt_r <= (take && fire_pin == PIN_WRITE) ? CNT_W'(WTR_CYC - 1) : cnt_dec(wtr_cnt_r);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      xsnr_cnt_r <= '0;
      xsrd_cnt_r <= '0;
    end else if (take && req_cmd == CMD_SREF_EXIT && state_r == ST_SELFREF) begin
      xsnr_cnt_r <= CNT_W'(XSNR_CYC - 1);
      xsrd_cnt_r <= CNT_W'(XSRD_CYC - 1);
    end else if (take && req_cmd == CMD_DLL_RESET) begin
      xsnr_cnt_r <= CNT_W'(DLL_CYC - 1);
      xsrd_cnt_r <= CNT_W'(DLL_CYC - 1);
    end else begin
      xsnr_cnt_r <= cnt_dec(xsnr_cnt_r);
      xsrd_cnt_r <= cnt_dec(xsrd_cnt_r);
    end
  end

  // ==================================================
  // Refresh bookkeeping; balance of 8 means on schedule
  always_ff @(posedge clk) begin
    if (rst || state_r == ST_SELFREF) begin
      refi_cnt_r <= CNT_W'(REFI_CYC - 1);
      refc_cnt_r <= CNT_W'(REFC_CYC - 1);
      bal_r      <= BAL_W'(REFRESH_POSTPONE_MAX);
    end else begin
      refi_cnt_r <= (refi_cnt_r == '0) ? CNT_W'(REFI_CYC - 1) : refi_cnt_r - 1'b1;
      refc_cnt_r <= (issue && fire_pin == PIN_REF) ? CNT_W'(REFC_CYC - 1)
                                                   : cnt_dec(refc_cnt_r);
      if (issue && fire_pin == PIN_REF && refi_cnt_r != '0) begin
        bal_r <= bal_r - 1'b1;
      end else if (!(issue && fire_pin == PIN_REF) && refi_cnt_r == '0
                   && bal_r != BAL_W'(2 * REFRESH_POSTPONE_MAX)) begin
        bal_r <= bal_r + 1'b1;
      end
    end
  end

  // ==================================================
  // Write strobe: low preamble from the command edge, toggles, low postamble
  always_ff @(posedge clk) begin
    if (rst) begin
      dqs_oe     <= 1'b0;
      dqs_o      <= 1'b0;
      dqs_step_r <= '0;
    end else if (take && fire_pin == PIN_WRITE) begin
      dqs_oe     <= 1'b1;
      dqs_o      <= 1'b0;
      dqs_step_r <= '0;
    end else if (dqs_oe) begin
      dqs_step_r <= dqs_step_r + 1'b1;
      dqs_o      <= dqs_step_r + 1'b1 >= STEP_W'(CK_DIV) && dqs_step_r + 1'b1 < STEP_W'(DQS_LAST)
                    && !dqs_step_r[0];
      if (dqs_step_r == STEP_W'(DQS_LAST)) begin
        dqs_oe <= 1'b0;
      end
    end
  end

  // ==================================================
  // Read strobe arrival
  always_ff @(posedge clk) begin
    if (rst) begin
      // Released strobe idles high: no false edge after reset
      dqs_s1_r         <= 1'b1;
      dqs_s2_r         <= 1'b1;
      dqs_s3_r         <= 1'b1;
      read_strobe_seen <= 1'b0;
    end else begin
      dqs_s1_r         <= dqs_i;
      dqs_s2_r         <= dqs_s1_r;
      dqs_s3_r         <= dqs_s2_r;
      read_strobe_seen <= dqs_s2_r && !dqs_s3_r && !dqs_oe;
    end
  end

  // ==================================================
  // Checks, measured from the pins
  logic [3:0]       pin_now;
  logic             seen;
  logic [CNT_W-1:0] since_act_r [NUM_BANKS];
  logic [CNT_W-1:0] since_any_act_r, since_ref_r, since_wr_r, since_srx_r;
  assign pin_now = {cs_n, ras_n, cas_n, we_n};
  assign seen    = !ck_r && pin_now != PIN_NOP;

  for (genvar h = 0; h < NUM_BANKS; h++) begin : g_since
    always_ff @(posedge clk) begin
      if (rst) since_act_r[h] <= '1;
      else since_act_r[h] <= (seen && pin_now == PIN_ACT && ba == 2'(h)) ? 12'h001
                                                                          : sat_inc(since_act_r[h]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      since_any_act_r <= '1;
      since_ref_r     <= '0;
      since_wr_r      <= '1;
      since_srx_r     <= '1;
    end else begin
      since_any_act_r <= (seen && pin_now == PIN_ACT) ? 12'h001 : sat_inc(since_any_act_r);
      since_ref_r     <= ((seen && pin_now == PIN_REF) || state_r == ST_SELFREF) ? 12'h001
                                                                  : sat_inc(since_ref_r);
      since_wr_r      <= (seen && pin_now == PIN_WRITE) ? 12'h001 : sat_inc(since_wr_r);
      since_srx_r     <= (cke && !$past(cke)) || (seen && pin_now == PIN_MRS) ? 12'h001
                                                                  : sat_inc(since_srx_r);
    end
  end

  sequence seq_cke_hold;
    cke [*2];
  endsequence

  AST_RW_AFTER_ACT: assert property (@(posedge clk) disable iff (rst)
    seen && (pin_now == PIN_READ || pin_now == PIN_WRITE) |-> since_act_r[ba] >= RW_CYC)
    else $error("read or write too soon after activate");
  AST_AP_AFTER_ACT: assert property (@(posedge clk) disable iff (rst)
    seen && addr_flag && pin_now != PIN_MRS |-> since_act_r[ba] >= RAS_CYC)
    else $error("autoprecharge too soon after activate");
  AST_ACT_SAME_BANK: assert property (@(posedge clk) disable iff (rst)
    seen && pin_now == PIN_ACT |-> since_act_r[ba] >= RC_CYC)
    else $error("same bank activates too close");
  AST_REF_SPACING: assert property (@(posedge clk) disable iff (rst)
    seen && (pin_now == PIN_ACT || pin_now == PIN_REF) |-> $past(since_ref_r) + 1 >= RFC_CYC)
    else $error("command inside refresh cycle");
  AST_ACT_OTHER_BANK: assert property (@(posedge clk) disable iff (rst)
    seen && pin_now == PIN_ACT |-> $past(since_any_act_r) + 1 >= RRD_CYC)
    else $error("activates too close");
  AST_WRITE_TO_READ: assert property (@(posedge clk) disable iff (rst)
    seen && pin_now == PIN_READ |-> since_wr_r >= WTR_CYC)
    else $error("read too soon after write data");
  AST_SRX_NONREAD: assert property (@(posedge clk) disable iff (rst)
    seen && pin_now != PIN_READ && pin_now != PIN_MRS |-> since_srx_r >= XSNR_CYC)
    else $error("command too soon after self refresh exit");
  AST_SRX_READ: assert property (@(posedge clk) disable iff (rst)
    seen && pin_now == PIN_READ |-> since_srx_r >= XSRD_CYC)
    else $error("read too soon after self refresh exit or dll reset");
  AST_REF_GAP: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_RUN |-> since_ref_r <= REFC_CYC)
    else $error("refresh gap exceeded");
  AST_REF_OWED: assert property (@(posedge clk) disable iff (rst)
    bal_r == BAL_W'(2 * REFRESH_POSTPONE_MAX) && state_r == ST_RUN
    |-> ##[1:500] (seen && pin_now == PIN_REF))
    else $error("postponed refreshes not repaid");
  AST_CKE_REFRESH: assert property (@(posedge clk) disable iff (rst)
    seen && pin_now == PIN_REF && cke |-> seq_cke_hold)
    else $error("clock enable dropped during refresh");
  AST_DQS_PREAMBLE: assert property (@(posedge clk) disable iff (rst)
    seen && pin_now == PIN_WRITE |-> dqs_oe && !dqs_o)
    else $error("strobe not driven low at write");
endmodule // ddr_guard_host

// ==== bench/ddr_device_model.sv ====
// Behavioural DDR device: pin timing checks and read strobe
`timescale 1ns/1ps
module ddr_device_model
  import ddr_guard_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ck_out,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic [1:0] ba,
  input  wire logic       addr_flag,
  input  wire logic       dqs_oe,
  output logic            dev_dqs,
  output int              viol_count,
  output int              ref_count
);
  // ==========
  // Limits in clk cycles
  function automatic int up(int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  localparam int RCD  = up(ACT_TO_RW_MIN_NS_FAST);
  localparam int RC   = up(ACT_TO_ACT_SAME_BANK_MIN_NS_FAST);
  localparam int RFC  = up(REFRESH_CYCLE_MIN_NS_FAST);
  localparam int RRD  = up(ACT_TO_ACT_OTHER_BANK_MIN_NS_FAST);
  localparam int RAS  = up(ACT_TO_PRE_MIN_NS_FAST);
  localparam int XSNR = up(SELFREF_EXIT_NONREAD_WAIT_NS);
  localparam int XSRD = CK_DIV * SELFREF_EXIT_READ_WAIT_CK;
  localparam int DLL  = CK_DIV * DLL_RESET_WAIT_CK;
  localparam int REFC = REFRESH_GAP_MAX_NS_SMALL / CLK_PERIOD_NS;
  localparam int REFI = REFRESH_INTERVAL_AVG_NS_SMALL / CLK_PERIOD_NS;
  // Last data one link period after write, burst, then the gap
  localparam int WTR  = CK_DIV * (2 + BURST_LEN / 2 + WRITE_TO_READ_GAP_CK) - CK_DIV;
  int         now, act_any, ref_t, wr_t, srx_t, mrs_t, tick, ticks, refs, rd_step;
  int         act_t [NUM_BANKS];
  logic       sref_r;
  logic [3:0] pin;
  assign pin = {cs_n, ras_n, cas_n, we_n};

  task automatic need(input bit ok);
    if (!ok) viol_count <= viol_count + 1;
  endtask

  // ==========
  // Command sampling at link clock rise
  always @(posedge clk) begin
    now <= now + 1;
    if (rst) begin
      act_t <= '{default: -100000};
      act_any <= -100000;
      wr_t <= -100000;
      srx_t <= -100000;
      mrs_t <= -100000;
      ref_t <= now;
      {tick, ticks, refs, rd_step, viol_count, ref_count} <= '0;
      sref_r <= 1'b0;
    end else begin
      tick <= (tick == REFI - 1) ? 0 : tick + 1;
      ticks <= ticks + int'(tick == REFI - 1 && !sref_r);
      rd_step <= (rd_step == 0 || rd_step > 10) ? 0 : rd_step + 1;
      // One interval of slack for the phase of the owed count
      need(ticks - refs <= REFRESH_POSTPONE_MAX + 1);
      need(refs - ticks <= REFRESH_POSTPONE_MAX + 1);
      need(sref_r || now - ref_t <= REFC);
      if (ck_out === 1'b0) begin
        if (now - ref_t < RFC && !sref_r) need(cke);
        if (sref_r && cke) begin
          sref_r <= 1'b0;
          srx_t <= now;
          ref_t <= now;
          ticks <= 0;
          refs <= 0;
        end
        case (pin)
          PIN_ACT: begin
            need(now - act_t[ba] >= RC && now - act_any >= RRD);
            need(now - ref_t >= RFC && now - srx_t >= XSNR);
            need(now - mrs_t >= DLL);
            act_t[ba] <= now;
            act_any <= now;
          end
          PIN_READ, PIN_WRITE: begin
            need(now - act_t[ba] >= RCD && now - mrs_t >= DLL);
            need(!addr_flag || now - act_t[ba] >= RAS);
            if (pin == PIN_WRITE) begin
              // Strobe presence only; setup sign and postamble length free
              need(dqs_oe && now - srx_t >= XSNR);
              wr_t <= now;
            end else begin
              need(now - wr_t >= WTR && now - srx_t >= XSRD);
              rd_step <= 1;
            end
          end
          PIN_REF: if (cke) begin
            need(now - ref_t >= RFC && now - act_any >= RC);
            ref_t <= now;
            refs <= refs + 1;
            ref_count <= ref_count + 1;
          end else sref_r <= 1'b1;
          PIN_MRS: if (addr_flag) mrs_t <= now;
          default: ;
        endcase
      end
    end
  end

  // Burst of four; released line shows inverse of last driven low
  always @(posedge clk)
    dev_dqs <= !(rd_step >= 4 && rd_step <= 10) || rd_step == 6 || rd_step == 8;
endmodule // ddr_device_model

// ==== bench/ddr_guard_host_tb.sv ====
// Self-checking bench for the DDR command guard host
`timescale 1ns/1ps
module ddr_guard_host_tb
  import ddr_guard_pkg::*;
;
  typedef struct {cmd_type c; logic [1:0] b; logic [3:0] p; logic f; bit m;} row_type;
  logic       clk, rst, req_valid, req_ack, ck_out, ck_n_out, cke, cs_n, ras_n, cas_n;
  logic       we_n, addr_flag, dqs_o, dqs_oe, dqs_i, read_strobe_seen, dev_dqs;
  logic [1:0] req_bank, ba;
  logic [3:0] pins;
  logic [13:0] w;
  cmd_type    req_cmd;
  int         n_fail, cmp_count, cyc, t0, k, n, viol_count, ref_count;
  row_type    rows [10] = '{
    '{CMD_ACT, 2'h0, PIN_ACT, 1'b0, 1'b1}, '{CMD_WRITE, 2'h0, PIN_WRITE, 1'b0, 1'b1},
    '{CMD_READ, 2'h0, PIN_READ, 1'b0, 1'b1}, '{CMD_ACT, 2'h1, PIN_ACT, 1'b0, 1'b1},
    '{CMD_READ_AP, 2'h1, PIN_READ, 1'b1, 1'b1}, '{CMD_WRITE_AP, 2'h0, PIN_WRITE, 1'b1, 1'b1},
    '{CMD_PRE, 2'h2, PIN_PRE, 1'b0, 1'b0}, '{CMD_REF, 2'h0, PIN_REF, 1'b0, 1'b0},
    '{CMD_NOP, 2'h0, PIN_NOP, 1'b0, 1'b0}, '{CMD_SREF_EXIT, 2'h0, PIN_NOP, 1'b0, 1'b0}};
  assign dqs_i = dqs_oe ? dqs_o : dev_dqs;

  ddr_guard_host ddr_guard_host_inst (.clk, .rst, .req_valid, .req_cmd, .req_bank, .req_ack,
    .ck_out, .ck_n_out, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr_flag, .dqs_o, .dqs_oe,
    .dqs_i, .read_strobe_seen);
  ddr_device_model ddr_device_model_inst (.clk, .rst, .ck_out, .cke, .cs_n, .ras_n, .cas_n,
    .we_n, .ba, .addr_flag, .dqs_oe, .dev_dqs, .viol_count, .ref_count);

  // ==========
  // Clock, counters, tasks
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  // Holds the request until the edge that samples the acknowledge
  task automatic send(input cmd_type c, input logic [1:0] b);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (req_ack !== 1'b1 && i < 3000);
    pins = {cs_n, ras_n, cas_n, we_n};
    req_valid <= 1'b0;
    if (i >= 3000) begin
      n_fail++;
      test_done();
    end
  endtask

  // ==========
  // Main sequence
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = CMD_NOP;
    req_bank = 2'h0;
    {n_fail, cmp_count, cyc} = '0;
    repeat (15) @(posedge clk);
    #1 chk(cke === 1'b1 && {cs_n, ras_n, cas_n, we_n} === PIN_NOP && ck_out === 1'b0
      && ba === 2'h0 && addr_flag === 1'b0 && dqs_oe === 1'b0 && req_ack === 1'b0
      && read_strobe_seen === 1'b0 && ck_n_out === 1'b1, "reset state");
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(read_strobe_seen === 1'b0, "strobe edge after reset");
    $display("test reset done");
    send(CMD_ACT, 2'h2);
    send(CMD_READ, 2'h2);
    n = 0;
    repeat (30) begin
      @(posedge clk);
      if (read_strobe_seen === 1'b1) n++;
    end
    chk(n == 3, "read strobe rises");
    $display("test read strobe done");
    send(CMD_WRITE, 2'h2);
    w = '0;
    repeat (7) begin
      @(posedge clk);
      w = {w[11:0], dqs_oe, dqs_o};
    end
    chk(w === 14'h2BB8, "write strobe walk");
    $display("test write strobe done");
    for (k = 0; k < 10; k++) begin
      send(rows[k].c, rows[k].b);
      chk(pins === rows[k].p && (!rows[k].m || (ba === rows[k].b
        && addr_flag === rows[k].f)) && ck_n_out === !ck_out, "command pins");
    end
    $display("test command table done");
    send(CMD_DLL_RESET, 2'h0);
    chk(pins === PIN_MRS && addr_flag === 1'b1, "dll reset pins");
    t0 = cyc;
    send(CMD_ACT, 2'h3);
    chk(cyc - t0 >= CK_DIV * DLL_RESET_WAIT_CK, "dll reset wait");
    $display("test dll reset done");
    send(CMD_SREF_ENTER, 2'h0);
    chk(pins === PIN_REF && cke === 1'b0, "self refresh entry");
    repeat (40) @(posedge clk);
    chk(cke === 1'b0, "cke in self refresh");
    send(CMD_SREF_EXIT, 2'h0);
    t0 = cyc;
    send(CMD_ACT, 2'h0);
    send(CMD_READ, 2'h0);
    chk(cke === 1'b1 && cyc - t0 >= CK_DIV * SELFREF_EXIT_READ_WAIT_CK, "exit read");
    $display("test self refresh done");
    t0 = cyc;
    n = ref_count;
    for (k = 0; k < 10; k++) send(CMD_REF, 2'h0);
    repeat (3000) @(posedge clk);
    chk(ref_count - n >= (cyc - t0) / (REFRESH_INTERVAL_AVG_NS_SMALL / CLK_PERIOD_NS)
      - REFRESH_POSTPONE_MAX, "refresh rate");
    chk(viol_count == 0, "device timing");
    $display("test refresh done");
    test_done();
  end
endmodule // ddr_guard_host_tb
